// [core/watchdog_map.vh]
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH
// register byte addresses: each register index times four
`define SCS_INDEX 16'h0013
`define SVC_INDEX 16'h1ff0
`define ADDR_SCS 16'h004c
`define ADDR_SVC 16'h7fc0
`define ADDR_INT_STATUS 16'h8000
`define ADDR_INT_MASK 16'h8004
// system_control_status fields
`define BIT_STOP_FLAG 4
`define BIT_ILADDR_FLAG 3
`define BIT_WDOG_FLAG 2
`define BIT_RATE_HI 1
`define BIT_RATE_LO 0
`define BIT_SVC 0
// interrupt status / mask fields
`define INT_TIMEOUT 0
`define INT_LOCK 1
`define INT_WIDTH 2
// oscillator tick: 32.768 kHz reference derived from 40 MHz pclk
`define OSC_HZ 32768
`define PCLK_HZ 40000000
// 1 second minimum timeout = 2^15 oscillator ticks; rates double per code
`define BASE_TICKS 32768
`define CNT_W 18
`define DIV_W 11
`define RESET_PULSE 8'h08
`define RST_CNT_W 8
`define RST_IDLE_CNT 8'h00
`define RST_LAST_CNT 8'h01
`endif

// [core/watchdog_with_reset_cause.v]
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_map.vh"

// Overview of operation
// - unserviced watchdog timeout forces full system reset
// - write zero to bit0 service address clears counter
// - counter held clear in reset and stop
// - rate taken from first control register write
// - bits7-5 zero, flags 4-2, rate 1-0
// - stop flag set by illegal stop, cleared by power-on, external or watchdog reset
// - address flag set by illegal-address reset
// - watchdog flag set by watchdog reset
// - watchdog only with mask option, never software-disabled
// - rate bits load on first write only
// - rates 1,2,4,8 seconds; default one second
// - rate-loading write also clears counter
// - first control register write, of any value, locks rate
// - counting continues in wait mode
// - counter halts while oscillator is off
module watchdog_with_reset_cause #(
	parameter [`DIV_W-1:0] OSC_DIV = 11'd1220,
	parameter WATCHDOG_OPTION = 1
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire stop_mode,
	input wire osc_off,
	input wire wait_mode,
	input wire cause_power_on,
	input wire cause_external,
	input wire cause_illegal_address,
	input wire cause_illegal_stop,
	output reg system_reset_req,
	output reg irq
);

	// pin inputs synchronised through three flops; the first is read only by the second
	reg [2:0] stop_s_r;
	reg [2:0] osc_s_r;
	reg [2:0] por_s_r;
	reg [2:0] ext_s_r;
	reg [2:0] ila_s_r;
	reg [2:0] ils_s_r;
	reg stop_q_r;
	reg osc_q_r;
	reg por_q_r;
	reg ext_q_r;
	reg ila_q_r;
	reg ils_q_r;
	reg ila_prev_r;
	reg ils_prev_r;
	reg [`DIV_W-1:0] div_r;
	reg [`CNT_W-1:0] cnt_r;
	reg [1:0] rate_r;
	reg locked_r;
	reg stop_flag_r;
	reg iladdr_flag_r;
	reg wdog_flag_r;
	reg [`INT_WIDTH-1:0] int_status_r;
	reg [`INT_WIDTH-1:0] int_mask_r;
	reg [`RST_CNT_W-1:0] rst_cnt_r;
	reg [`RST_CNT_W-1:0] rst_cnt_nxt;
	reg [1:0] pulse_state_r;
	reg [1:0] pulse_state_nxt;
	reg req_nxt;
	reg [31:0] prdata_nxt;
	reg pslverr_nxt;

	// reset pulse sequencer states, one-hot
	localparam [1:0] PULSE_IDLE = 2'b01;
	localparam [1:0] PULSE_HIGH = 2'b10;

	wire acc = psel & penable;
	wire setup = psel & ~penable;
	wire wr = acc & pwrite;
	wire rd_setup = setup & ~pwrite;
	wire wr_scs = wr & hit(paddr, `ADDR_SCS);
	wire svc = wr & hit(paddr, `ADDR_SVC) & ~pwdata[`BIT_SVC];
	wire first_wr = wr_scs & ~locked_r;
	// tick is gated by osc_off so a frozen divider cannot fire a timeout
	wire tick = (div_r == OSC_DIV) & ~osc_q_r;
	wire pulse_busy = (pulse_state_r == PULSE_HIGH);
	wire cnt_clr = svc | first_wr | stop_q_r | pulse_busy;
	wire timeout;
	wire fire;
	wire ila_evt = ila_q_r & ~ila_prev_r;
	wire ils_evt = ils_q_r & ~ils_prev_r;
	wire [7:0] scs_val;

	// terminal count of the chain, cut to the counter width on purpose
	function [`CNT_W-1:0] last_count;
		input [1:0] sel;
		reg [31:0] full;
		begin
			full = (`BASE_TICKS << sel) - 1;
			last_count = full[`CNT_W-1:0];
		end
	endfunction

	function hit;
		input [15:0] addr;
		input [15:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	function filt;
		input [2:0] s;
		input q;
		begin
			filt = (s[2] == s[1]) ? s[2] : q;
		end
	endfunction

	// a service in the last cycle wins over the timeout
	assign timeout = tick & ~cnt_clr & (cnt_r == last_count(rate_r));
	assign fire = timeout & (WATCHDOG_OPTION != 0);
	assign scs_val = {3'b000, stop_flag_r, iladdr_flag_r, wdog_flag_r, rate_r};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_s_r <= 3'b000;
			stop_q_r <= 1'b0;
		end else begin
			stop_s_r <= {stop_s_r[1:0], stop_mode};
			stop_q_r <= filt(stop_s_r, stop_q_r);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_s_r <= 3'b000;
			osc_q_r <= 1'b0;
		end else begin
			osc_s_r <= {osc_s_r[1:0], osc_off};
			osc_q_r <= filt(osc_s_r, osc_q_r);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_s_r <= 3'b000;
			por_q_r <= 1'b0;
		end else begin
			por_s_r <= {por_s_r[1:0], cause_power_on};
			por_q_r <= filt(por_s_r, por_q_r);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s_r <= 3'b000;
			ext_q_r <= 1'b0;
		end else begin
			ext_s_r <= {ext_s_r[1:0], cause_external};
			ext_q_r <= filt(ext_s_r, ext_q_r);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ila_s_r <= 3'b000;
			ila_q_r <= 1'b0;
			ila_prev_r <= 1'b0;
		end else begin
			ila_s_r <= {ila_s_r[1:0], cause_illegal_address};
			ila_q_r <= filt(ila_s_r, ila_q_r);
			ila_prev_r <= ila_q_r;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ils_s_r <= 3'b000;
			ils_q_r <= 1'b0;
			ils_prev_r <= 1'b0;
		end else begin
			ils_s_r <= {ils_s_r[1:0], cause_illegal_stop};
			ils_q_r <= filt(ils_s_r, ils_q_r);
			ils_prev_r <= ils_q_r;
		end
	end

	// oscillator-rate prescaler; wait_mode deliberately not used so counting goes on
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= {`DIV_W{1'b0}};
		end else if (osc_q_r) begin
			div_r <= div_r;
		end else if (tick) begin
			div_r <= {`DIV_W{1'b0}};
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= {`CNT_W{1'b0}};
		end else if (stop_q_r || pulse_busy) begin
			cnt_r <= {`CNT_W{1'b0}};
		end else if (svc || first_wr) begin
			cnt_r <= {`CNT_W{1'b0}};
		end else if (tick) begin
			cnt_r <= timeout ? {`CNT_W{1'b0}} : cnt_r + 1'b1;
		end
	end

	// rate locks on the first write; a rmw bit op writes back the default value
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_r <= 2'b00;
			locked_r <= 1'b0;
		end else if (first_wr) begin
			rate_r <= pwdata[`BIT_RATE_HI:`BIT_RATE_LO];
			locked_r <= 1'b1;
		end
	end

	// reset-cause flags; bus writes never reach them, and they survive presetn
	always @(posedge pclk) begin
		if (por_q_r || ext_q_r) begin
			stop_flag_r <= 1'b0;
			iladdr_flag_r <= 1'b0;
			wdog_flag_r <= 1'b0;
		end else if (fire) begin
			stop_flag_r <= 1'b0;
			iladdr_flag_r <= 1'b0;
			wdog_flag_r <= 1'b1;
		end else if (ila_evt) begin
			iladdr_flag_r <= 1'b1;
			wdog_flag_r <= 1'b0;
		end else if (ils_evt) begin
			stop_flag_r <= 1'b1;
		end
	end

	// reset request stretched so the system sees a clean pulse
	always @* begin
		pulse_state_nxt = pulse_state_r;
		rst_cnt_nxt = rst_cnt_r;
		req_nxt = 1'b0;
		case (pulse_state_r)
		PULSE_IDLE: begin
			if (fire) begin
				pulse_state_nxt = PULSE_HIGH;
				rst_cnt_nxt = `RESET_PULSE;
				req_nxt = 1'b1;
			end
		end
		PULSE_HIGH: begin
			rst_cnt_nxt = rst_cnt_r - 1'b1;
			req_nxt = (rst_cnt_r != `RST_LAST_CNT);
			if (rst_cnt_r == `RST_LAST_CNT)
				pulse_state_nxt = PULSE_IDLE;
		end
		default: begin
			pulse_state_nxt = PULSE_IDLE;
			rst_cnt_nxt = `RST_IDLE_CNT;
		end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_state_r <= PULSE_IDLE;
			rst_cnt_r <= `RST_IDLE_CNT;
			system_reset_req <= 1'b0;
		end else begin
			pulse_state_r <= pulse_state_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			system_reset_req <= req_nxt;
		end
	end

	// status clears when its read is set up; the read data already holds the old value,
	// and an event in that same cycle still wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status_r <= {`INT_WIDTH{1'b0}};
		end else begin
			int_status_r <= ((rd_setup && hit(paddr, `ADDR_INT_STATUS)) ? {`INT_WIDTH{1'b0}} : int_status_r)
				| {first_wr, timeout};
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask_r <= {`INT_WIDTH{1'b0}};
		end else if (wr && hit(paddr, `ADDR_INT_MASK)) begin
			int_mask_r <= pwdata[`INT_WIDTH-1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status_r & int_mask_r);
		end
	end

	// read data is formed at the setup edge so the access phase needs no wait state
	always @* begin
		prdata_nxt = 32'h0000_0000;
		pslverr_nxt = 1'b0;
		if (setup) begin
			case (paddr)
			`ADDR_SCS: prdata_nxt = {24'h000000, scs_val};
			`ADDR_SVC: prdata_nxt = 32'h0000_0000;
			`ADDR_INT_STATUS: prdata_nxt = {30'h00000000, int_status_r};
			`ADDR_INT_MASK: prdata_nxt = {30'h00000000, int_mask_r};
			default: pslverr_nxt = 1'b1;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= pslverr_nxt;
			prdata <= prdata_nxt;
		end
	end

endmodule
`default_nettype wire

// [verification/watchdog_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_map.vh"
module watchdog_chk (
	input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stop_mode, osc_off, system_reset_req,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata, prdata
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_zero_wait: assert property (psel && !penable |=> pready) else $error("no ready");
	chk_bad_addr: assert property (psel && !penable && paddr == 16'h0100 |=> pslverr) else $error("no refusal");
	chk_upper_zero: assert property (pready && !pwrite && paddr == `ADDR_SCS |-> !prdata[31:5])
		else $error("upper bits set");
	chk_reset_pulse: assert property ($rose(system_reset_req) |-> system_reset_req[*8] ##1 !system_reset_req)
		else $error("reset pulse length");
	chk_svc_defer: assert property (psel && penable && pwrite && paddr == `ADDR_SVC && !pwdata[0]
		|=> (!$rose(system_reset_req))[*8]) else $error("reset after service");
	chk_stop_hold: assert property (stop_mode[*8] |-> !$rose(system_reset_req)) else $error("reset in stop");
	chk_osc_freeze: assert property (osc_off[*8] |-> !$rose(system_reset_req)) else $error("count ran");
	chk_wdog_flag: assert property ($fell(system_reset_req) ##[1:12] (pready && !pwrite && paddr == `ADDR_SCS)
		|-> prdata[2]) else $error("flag missing");
endmodule
bind watchdog_with_reset_cause watchdog_chk watchdog_chk_inst (.*);
`default_nettype wire

// [verification/watchdog_with_reset_cause_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_map.vh"
module watchdog_with_reset_cause_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, system_reset_req, irq, stop_mode, osc_off;
	logic wait_mode, cause_power_on, cause_external, cause_illegal_address, cause_illegal_stop;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int n_errors = 0, n_compared = 0, cyc = 0, t, rate_m = 0, flags_m = 0;
	// divider zero: one tick per cycle keeps a timeout near 32768 cycles
	watchdog_with_reset_cause #(.OSC_DIV(11'd0)) watchdog_with_reset_cause_inst (.*);
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic report_and_stop;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 80000) begin
			n_errors++;
			report_and_stop;
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
		r = prdata;
		chk("pready", 1, pready);
		chk("pslverr", a == 16'h0100, pslverr);
		{psel, penable} <= 2'h0;
	endtask
	task automatic scs;
		bus(0, `ADDR_SCS, 0);
		chk("scs", flags_m * 4 + rate_m, r);
	endtask
	task automatic cause(input int i);
		@(posedge pclk);
		{cause_illegal_stop, cause_illegal_address, cause_external} <= 3'(1 << i);
		repeat (8) @(posedge pclk);
		{cause_illegal_stop, cause_illegal_address, cause_external} <= 3'h0;
		repeat (8) @(posedge pclk);
	endtask
	initial begin
		{psel, penable, pwrite, stop_mode, osc_off, wait_mode, presetn, cause_power_on} = 8'h1;
		{cause_illegal_stop, cause_illegal_address, cause_external, paddr, pwdata} = 0;
		void'($urandom(32'h744287a2));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		repeat (8) @(posedge pclk);
		cause_power_on <= 0;
		repeat (8) @(posedge pclk);
		scs();
		bus(1, `ADDR_SVC, 0);
		stop_mode <= 1;
		repeat (12) @(posedge pclk);
		{stop_mode, osc_off} <= 2'h1;
		repeat (12) @(posedge pclk);
		osc_off <= 0;
		bus(1, `ADDR_SCS, $urandom & 32'hfffffffc);
		bus(1, `ADDR_SCS, 32'h3);
		scs();
		bus(0, 16'h0100, 0);
		bus(1, `ADDR_INT_MASK, 32'h1);
		cause(1);
		flags_m = 2;
		scs();
		cause(2);
		flags_m = 6;
		scs();
		wait_mode <= 1;
		repeat (30000) @(posedge pclk);
		bus(1, `ADDR_SVC, $urandom & 32'hfffffffe);
		t = 0;
		do begin @(posedge pclk); t++; end while (system_reset_req !== 1'b1 && t < 40000);
		chk("timeout", 1, t > 32760 && t < 32800);
		repeat (10) @(posedge pclk);
		flags_m = 1;
		scs();
		chk("irq", 1, irq);
		bus(0, `ADDR_INT_STATUS, 0);
		chk("status", 1, r & 1);
		repeat (3) @(posedge pclk);
		chk("irq", 0, irq);
		cause(1);
		flags_m = 2;
		scs();
		cause(0);
		flags_m = 0;
		scs();
		report_and_stop;
	end
endmodule
`default_nettype wire
